// [hdl/tsw_cfg.svh]
`ifndef TSW_CFG_SVH
`define TSW_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TSW_OFF_MOD_FAULT   8'h00
`define TSW_OFF_CHAN_FAULT  8'h04
`define TSW_OFF_CHAN_STAT   8'h08
`define TSW_OFF_IRQ_STAT    8'h0C
`define TSW_OFF_IRQ_MASK    8'h10
`define TSW_OFF_MIN_LEVEL   8'h14
`define TSW_OFF_MAX_LEVEL   8'h18
`define TSW_OFF_CJ_TEMP     8'h1C

// ****************************************
// Module fault word bit positions
// ****************************************
`define TSW_MF_ANALOG_GRP   15
`define TSW_MF_INPUT_GRP    14
`define TSW_MF_CALIBRATING  13
`define TSW_MF_CJ_LOW       11
`define TSW_MF_CJ_HIGH      10
`define TSW_MF_CAL_FAULT    9

// ****************************************
// Channel words
// ****************************************
`define TSW_NUM_CHAN        6
`define TSW_STAT_LOW_TOP    15
`define TSW_STAT_HIGH_TOP   14
`define TSW_CF_CAL_PATTERN  16'h003F
`define TSW_CF_COMM_PATTERN 16'hFFFF

// ****************************************
// Cold junction limits, sample in 1/16 degC
// ****************************************
`define TSW_CJ_FRAC_BITS    4
`define TSW_CJ_LOW_DEGC     0
`define TSW_CJ_HIGH_DEGC    86

// ****************************************
// Interrupt status bits
// ****************************************
`define TSW_IRQ_W           6
`define TSW_IRQ_CH_LOW      0
`define TSW_IRQ_CH_HIGH     1
`define TSW_IRQ_CAL_FAULT   2
`define TSW_IRQ_CJ_LOW      3
`define TSW_IRQ_CJ_HIGH     4
`define TSW_IRQ_COMM        5

// ****************************************
// Reset values
// ****************************************
`define TSW_RST_WORD        16'h0000
`define TSW_RST_IRQ         6'h00
`define TSW_RST_MIN_LEVEL   16'h8000
`define TSW_RST_MAX_LEVEL   16'h7FFF

`endif

// [hdl/tsw_pkg.sv]
`default_nettype none
`include "tsw_cfg.svh"

package tsw_pkg;
    typedef logic        [15:0]              tsw_word_t;
    typedef logic signed [15:0]              tsw_sample_t;
    typedef logic        [`TSW_NUM_CHAN-1:0] tsw_chan_vec_t;
    typedef logic        [`TSW_IRQ_W-1:0]    tsw_irq_vec_t;
    typedef logic        [16*`TSW_NUM_CHAN-1:0] tsw_samples_t;
endpackage
`default_nettype wire

// [hdl/tsw_chan_range.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tsw_cfg.svh"

module tsw_chan_range (
    input  wire  logic                 pclk,
    input  wire  logic                 presetn,
    input  wire  tsw_pkg::tsw_samples_t chan_value,
    input  wire  tsw_pkg::tsw_sample_t min_level,
    input  wire  tsw_pkg::tsw_sample_t max_level,
    output logic [`TSW_NUM_CHAN-1:0]   channel_low_range_flag,
    output logic [`TSW_NUM_CHAN-1:0]   channel_high_range_flag
);
    import tsw_pkg::*;

    // ****************************************
    // Per-channel range compare
    // ****************************************
    genvar ch;
    generate
        for (ch = 0; ch < `TSW_NUM_CHAN; ch = ch + 1) begin : g_chan
            tsw_sample_t sample;
            assign sample = tsw_sample_t'(chan_value[16*ch +: 16]);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    channel_low_range_flag[ch]  <= 1'b0;
                    channel_high_range_flag[ch] <= 1'b0;
                end else begin
                    // Inclusive edges
                    channel_low_range_flag[ch]  <= (sample <= min_level);
                    channel_high_range_flag[ch] <= (sample >= max_level);
                end
            end
        end
    endgenerate

endmodule // tsw_chan_range
`default_nettype wire

// [hdl/tsw_fault_words.sv]
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tsw_cfg.svh"

// How it works
// - Module flags sit in bits 15 to 8
// - Analog group set when channel fault nonzero
// - Input group mirrors analog group fault
// - Calibrating sets flag and forces fault word
// - Any channel calibration fault sets module flag
// - Channel calibration fault drives module bit 9
// - Junction below zero degrees sets low flag
// - Junction above 86 degrees sets high flag
// - Calibration without link loss shows fault word 003F
// - Communication loss shows fault word FFFF
// - Status reports only under and over range
// - No per-channel cal status, module flag kept
// - One packed status word for six channels
// - Low range flags on odd bits 15..5
// - High range flags on even bits 14..4
// - At or below minimum sets low, fault bit
// - At or above maximum sets high, fault bit
module tsw_fault_words (
    input  wire  logic                  pclk,
    input  wire  logic                  presetn,
    input  wire  logic [7:0]            paddr,
    input  wire  logic                  psel,
    input  wire  logic                  penable,
    input  wire  logic                  pwrite,
    input  wire  logic [31:0]           pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire  tsw_pkg::tsw_samples_t chan_value,
    input  wire  tsw_pkg::tsw_sample_t  cj_temp,
    input  wire  tsw_pkg::tsw_chan_vec_t chan_cal_active,
    input  wire  tsw_pkg::tsw_chan_vec_t chan_cal_bad,
    input  wire  logic                  comm_fault,
    output tsw_pkg::tsw_word_t          module_fault_flags_word,
    output tsw_pkg::tsw_word_t          channel_fault_summary_word,
    output tsw_pkg::tsw_word_t          packed_channel_range_status,
    output logic                        irq
);
    import tsw_pkg::*;

    // ****************************************
    // Declarations
    // ****************************************
    localparam tsw_sample_t CJ_LOW_LIMIT =
        tsw_sample_t'(`TSW_CJ_LOW_DEGC <<< `TSW_CJ_FRAC_BITS);
    localparam tsw_sample_t CJ_HIGH_LIMIT =
        tsw_sample_t'(`TSW_CJ_HIGH_DEGC <<< `TSW_CJ_FRAC_BITS);

    tsw_sample_t   min_level_reg;
    tsw_sample_t   max_level_reg;
    tsw_irq_vec_t  irq_status_reg;
    tsw_irq_vec_t  irq_mask_reg;
    tsw_irq_vec_t  irq_event;
    tsw_chan_vec_t low_flag;
    tsw_chan_vec_t high_flag;
    tsw_word_t     chan_fault_next;
    tsw_word_t     chan_status_next;
    tsw_word_t     mod_fault_next;
    logic          cal_any;
    logic          cal_bad_any;
    logic          cj_low;
    logic          cj_high;
    logic          wr_fire;
    logic          rd_fire;
    logic [31:0]   rd_data;
    logic          rd_hit;

    // ****************************************
    // Channel range detection
    // ****************************************
    tsw_chan_range u_range (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .chan_value              (chan_value),
        .min_level               (min_level_reg),
        .max_level               (max_level_reg),
        .channel_low_range_flag  (low_flag),
        .channel_high_range_flag (high_flag)
    );

    assign cal_any     = |chan_cal_active;
    // Per-channel cal status is not reported, only its rollup
    assign cal_bad_any = |chan_cal_bad;
    assign cj_low      = (cj_temp < CJ_LOW_LIMIT);
    assign cj_high     = (cj_temp > CJ_HIGH_LIMIT);

    // ****************************************
    // Word assembly
    // ****************************************
    always_comb begin
        chan_status_next = `TSW_RST_WORD;
        for (int i = 0; i < `TSW_NUM_CHAN; i++) begin
            // Alarm bits have no place here
            chan_status_next[`TSW_STAT_LOW_TOP - 2*i]  = low_flag[i];
            chan_status_next[`TSW_STAT_HIGH_TOP - 2*i] = high_flag[i];
        end
    end

    always_comb begin
        chan_fault_next = `TSW_RST_WORD;
        if (comm_fault) begin
            // Link loss wins over calibration
            chan_fault_next = `TSW_CF_COMM_PATTERN;
        end else if (cal_any) begin
            chan_fault_next = `TSW_CF_CAL_PATTERN;
        end else begin
            for (int i = 0; i < `TSW_NUM_CHAN; i++) begin
                chan_fault_next[i] = low_flag[i] | high_flag[i];
            end
        end
    end

    always_comb begin
        mod_fault_next = `TSW_RST_WORD;
        // Low byte stays zero
        mod_fault_next[`TSW_MF_ANALOG_GRP]  = |chan_fault_next;
        mod_fault_next[`TSW_MF_INPUT_GRP]   = |chan_fault_next;
        mod_fault_next[`TSW_MF_CALIBRATING] = cal_any;
        mod_fault_next[`TSW_MF_CJ_LOW]      = cj_low;
        mod_fault_next[`TSW_MF_CJ_HIGH]     = cj_high;
        mod_fault_next[`TSW_MF_CAL_FAULT]   = cal_bad_any;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            module_fault_flags_word     <= `TSW_RST_WORD;
            channel_fault_summary_word  <= `TSW_RST_WORD;
            packed_channel_range_status <= `TSW_RST_WORD;
        end else begin
            module_fault_flags_word     <= mod_fault_next;
            channel_fault_summary_word  <= chan_fault_next;
            packed_channel_range_status <= chan_status_next;
        end
    end

    // ****************************************
    // APB slave, one wait state
    // ****************************************
    assign wr_fire = psel & penable & pready & pwrite;
    assign rd_fire = psel & penable & ~pready;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case (paddr)
            `TSW_OFF_MOD_FAULT:  rd_data[15:0] = module_fault_flags_word;
            `TSW_OFF_CHAN_FAULT: rd_data[15:0] = channel_fault_summary_word;
            `TSW_OFF_CHAN_STAT:  rd_data[15:0] = packed_channel_range_status;
            `TSW_OFF_IRQ_STAT:   rd_data[`TSW_IRQ_W-1:0] = irq_status_reg;
            `TSW_OFF_IRQ_MASK:   rd_data[`TSW_IRQ_W-1:0] = irq_mask_reg;
            `TSW_OFF_MIN_LEVEL:  rd_data[15:0] = min_level_reg;
            `TSW_OFF_MAX_LEVEL:  rd_data[15:0] = max_level_reg;
            `TSW_OFF_CJ_TEMP:    rd_data[15:0] = cj_temp;
            default:             rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_fire;
            prdata  <= rd_fire && !pwrite ? rd_data : 32'h0000_0000;
            pslverr <= rd_fire & ~rd_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            min_level_reg <= tsw_sample_t'(`TSW_RST_MIN_LEVEL);
            max_level_reg <= tsw_sample_t'(`TSW_RST_MAX_LEVEL);
            irq_mask_reg  <= `TSW_RST_IRQ;
        end else if (wr_fire) begin
            if (paddr == `TSW_OFF_MIN_LEVEL) begin
                min_level_reg <= tsw_sample_t'(pwdata[15:0]);
            end
            if (paddr == `TSW_OFF_MAX_LEVEL) begin
                max_level_reg <= tsw_sample_t'(pwdata[15:0]);
            end
            if (paddr == `TSW_OFF_IRQ_MASK) begin
                irq_mask_reg <= pwdata[`TSW_IRQ_W-1:0];
            end
        end
    end

    // ****************************************
    // Interrupts
    // ****************************************
    always_comb begin
        irq_event = `TSW_RST_IRQ;
        irq_event[`TSW_IRQ_CH_LOW]    = |low_flag;
        irq_event[`TSW_IRQ_CH_HIGH]   = |high_flag;
        irq_event[`TSW_IRQ_CAL_FAULT] = cal_bad_any;
        irq_event[`TSW_IRQ_CJ_LOW]    = cj_low;
        irq_event[`TSW_IRQ_CJ_HIGH]   = cj_high;
        irq_event[`TSW_IRQ_COMM]      = comm_fault;
    end

    // Set beats write-one-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= `TSW_RST_IRQ;
        end else if (wr_fire && paddr == `TSW_OFF_IRQ_STAT) begin
            irq_status_reg <= (irq_status_reg & ~pwdata[`TSW_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status_reg <= irq_status_reg | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_reg | irq_event) & irq_mask_reg);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence apb_access_s;
        psel && penable && !pready;
    endsequence

    sequence apb_write_s;
        psel && penable && pready && pwrite;
    endsequence

    sequence comm_clear_s;
        apb_write_s ##0 paddr == `TSW_OFF_IRQ_STAT && pwdata[`TSW_IRQ_COMM];
    endsequence

    apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_setup_s ##1 apb_access_s |=> pready ##1 !pready)
        else $error("APB answer not after one wait cycle");

    comm_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        comm_fault |=> channel_fault_summary_word == 16'hFFFF)
        else $error("Fault word not FFFF on link loss");

    cal_force_a: assert property (@(posedge pclk) disable iff (!presetn)
        cal_any && !comm_fault |=> channel_fault_summary_word == 16'h003F
            && module_fault_flags_word[13])
        else $error("Calibration pattern missing");

    group_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        module_fault_flags_word[15] == (channel_fault_summary_word != 16'h0000)
            && module_fault_flags_word[14] == module_fault_flags_word[15])
        else $error("Group fault flags disagree with fault word");

    cal_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
        (chan_cal_bad != 6'h00) |=> module_fault_flags_word[9])
        else $error("Calibration fault bit 9 missing");

    cj_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 module_fault_flags_word[11] == ($past(cj_temp) < 0)
            && module_fault_flags_word[10] == ($past(cj_temp) > 16'sd1376))
        else $error("Junction range flag wrong");

    pack_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##2 packed_channel_range_status[15] ==
            ($signed($past(chan_value[15:0], 2)) <= $past(min_level_reg, 2))
            && packed_channel_range_status[3:0] == 4'h0)
        else $error("Channel 0 low range bit wrong");

    pack_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        packed_channel_range_status[4] == $past(high_flag[5]))
        else $error("Channel 5 high range bit wrong");

    fault_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        !comm_fault && !cal_any |=> channel_fault_summary_word[15:6] == 10'h000
            && channel_fault_summary_word[0] == ($past(low_flag[0]) | $past(high_flag[0])))
        else $error("Channel fault bit mapping wrong");

    comm_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_event[`TSW_IRQ_COMM] |=> irq_status_reg[`TSW_IRQ_COMM]
            ##1 (irq_status_reg[`TSW_IRQ_COMM]
                || $past(wr_fire && paddr == `TSW_OFF_IRQ_STAT && pwdata[`TSW_IRQ_COMM])))
        else $error("Sticky status lost an event");

    comm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        comm_clear_s ##0 !irq_event[`TSW_IRQ_COMM] |=> !irq_status_reg[`TSW_IRQ_COMM])
        else $error("Status bit not cleared by writing one");

    min_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_write_s ##0 paddr == `TSW_OFF_MIN_LEVEL |=> min_level_reg == $past(pwdata[15:0]))
        else $error("Minimum level write lost");

    mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        apb_write_s ##0 paddr == `TSW_OFF_IRQ_MASK
            |=> irq_mask_reg == $past(pwdata[`TSW_IRQ_W-1:0]))
        else $error("Mask write lost");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("Ready held longer than one cycle");

    err_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("Error response without ready or with data");

    idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
        !pready |-> prdata == 32'h0000_0000)
        else $error("Read data outside ready cycle");

    input_group_a: assert property (@(posedge pclk) disable iff (!presetn)
        module_fault_flags_word[14] == (channel_fault_summary_word != 16'h0000))
        else $error("Input group flag disagrees with fault word");

    low_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
        module_fault_flags_word[7:0] == 8'h00 && !module_fault_flags_word[12])
        else $error("Unused module fault bits set");

    cal_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
        cal_any |=> module_fault_flags_word[13]
            && channel_fault_summary_word[5:0] == 6'h3F)
        else $error("Calibrating flag or forced bits missing");

    comm_group_a: assert property (@(posedge pclk) disable iff (!presetn)
        comm_fault |=> module_fault_flags_word[15] && module_fault_flags_word[14])
        else $error("Group flags not set on link loss");

    fault_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        !comm_fault && !cal_any
            |=> channel_fault_summary_word[5:0] == $past(low_flag | high_flag))
        else $error("Channel fault bits disagree with range flags");

    pack_chan0_a: assert property (@(posedge pclk) disable iff (!presetn)
        packed_channel_range_status[15] == $past(low_flag[0])
            && packed_channel_range_status[14] == $past(high_flag[0]))
        else $error("Channel 0 status bits wrong");

    masked_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq_mask_reg == 6'h00 |=> !irq)
        else $error("Interrupt raised with all sources masked");

endmodule // tsw_fault_words
`default_nettype wire

// [dv/tsw_owner_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Owner controller: APB master reaching the status words
// ****************************************
module tsw_owner_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output var  logic [7:0]  paddr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] pwdata
);
    initial begin
        paddr   = 8'h00;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        pwdata  = 32'h0000_0000;
    end

    // Request held until pready seen high at a rising edge
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er, output logic to);
        int i;
        to = 1'b1;
        rd = 32'h0000_0000;
        er = 1'b0;
        @(posedge pclk);
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= wd;
        psel    <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && to; i++) begin
            // Taken at the very edge that sees pready high
            @(posedge pclk);
            if (pready === 1'b1) begin
                rd = prdata;
                er = pslverr;
                to = 1'b0;
            end
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        // Stale data replaced so a late sample cannot match
        pwdata  <= ~wd;
    endtask
endmodule // tsw_owner_model

`default_nettype wire

// [dv/tb_integer_mode_fault_status_words.sv]
`timescale 1ns/1ns
`default_nettype none
`include "tsw_cfg.svh"

module tb_integer_mode_fault_status_words;
    import tsw_pkg::*;

    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic [7:0]    paddr;
    logic          psel, penable, pwrite, pready, pslverr, irq;
    logic [31:0]   pwdata, prdata, rd;
    logic          er;
    tsw_samples_t  chan_value = '0;
    tsw_sample_t   cj_temp = '0;
    tsw_sample_t   mn, mx, s;
    tsw_chan_vec_t chan_cal_active = '0;
    tsw_chan_vec_t chan_cal_bad = '0;
    logic          comm_fault = 1'b0;
    tsw_word_t     module_fault_flags_word, channel_fault_summary_word;
    tsw_word_t     packed_channel_range_status;
    int            n_errors = 0;
    int            checked = 0;
    int            cj_tab [4] = '{-1, 0, 1376, 1377};

    always #4 pclk = ~pclk;

    tsw_fault_words DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .chan_value(chan_value), .cj_temp(cj_temp),
        .chan_cal_active(chan_cal_active), .chan_cal_bad(chan_cal_bad),
        .comm_fault(comm_fault), .module_fault_flags_word(module_fault_flags_word),
        .channel_fault_summary_word(channel_fault_summary_word),
        .packed_channel_range_status(packed_channel_range_status), .irq(irq)
    );

    tsw_owner_model u_ctrl (
        .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata)
    );

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        logic to;
        u_ctrl.xfer(a, wr, wd, rd, er, to);
        if (to) begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    // Expected words from the current stimulus
    task automatic check_all();
        tsw_word_t st, cf, mf;
        st = '0;
        cf = '0;
        for (int n = 0; n < 6; n++) begin
            s = chan_value[16*n +: 16];
            st[15-2*n] = (s <= mn);
            st[14-2*n] = (s >= mx);
            cf[n] = (s <= mn) | (s >= mx);
        end
        if (comm_fault) cf = 16'hFFFF;
        else if (|chan_cal_active) cf = 16'h003F;
        mf = '0;
        mf[15] = |cf;
        mf[14] = |cf;
        mf[13] = |chan_cal_active;
        mf[11] = (cj_temp < 0);
        mf[10] = (cj_temp > 1376);
        mf[9]  = |chan_cal_bad;
        chk("chan_status", packed_channel_range_status, st);
        chk("chan_fault", channel_fault_summary_word, cf);
        chk("mod_fault", module_fault_flags_word, mf);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'h0b3c));
        mn = 16'h8000;
        mx = 16'h7FFF;
        repeat (20) @(posedge pclk);
        chk("reset_irq", irq, 1'b0);
        presetn <= 1'b1;
        apb(`TSW_OFF_MIN_LEVEL, 1'b0, 32'h0);
        chk("min_rst", rd, 32'h0000_8000);
        apb(`TSW_OFF_MAX_LEVEL, 1'b0, 32'h0);
        chk("max_rst", rd, 32'h0000_7FFF);
        apb(`TSW_OFF_IRQ_MASK, 1'b0, 32'h0);
        chk("mask_rst", rd, 32'h0);
        apb(8'h20, 1'b0, 32'h0);
        chk("unmapped", {rd[30:0], er}, 32'h1);
        apb(`TSW_OFF_CHAN_FAULT, 1'b1, 32'hFFFF);
        chk("ro_write", er, 1'b0);
        settle();
        check_all();
        // Random mix with thresholds hit exactly and missed by one
        for (int i = 0; i < 24; i++) begin
            mn = tsw_sample_t'(-($urandom % 1000) - 1);
            mx = tsw_sample_t'(($urandom % 1000) + 1);
            apb(`TSW_OFF_MIN_LEVEL, 1'b1, {16'h0, mn});
            apb(`TSW_OFF_MAX_LEVEL, 1'b1, {16'h0, mx});
            @(posedge pclk);
            for (int n = 0; n < 6; n++)
                case ($urandom % 5)
                    0: chan_value[16*n +: 16] <= mn;
                    1: chan_value[16*n +: 16] <= 16'(mn + 1);
                    2: chan_value[16*n +: 16] <= mx;
                    3: chan_value[16*n +: 16] <= 16'(mx - 1);
                    default: chan_value[16*n +: 16] <= 16'($urandom);
                endcase
            chan_cal_active <= ($urandom % 4 == 0) ? 6'h01 << (i % 6) : 6'h00;
            chan_cal_bad <= ($urandom % 4 == 0) ? 6'h20 >> (i % 6) : 6'h00;
            comm_fault <= ($urandom % 6 == 0);
            cj_temp <= tsw_sample_t'((i < 4) ? cj_tab[i] : $urandom % 2000 - 200);
            settle();
            check_all();
        end
        // Sticky comm event, cleared by writing one, then masked
        @(posedge pclk);
        comm_fault <= 1'b0;
        apb(`TSW_OFF_IRQ_STAT, 1'b1, 32'h3F);
        apb(`TSW_OFF_IRQ_MASK, 1'b1, 32'h20);
        settle();
        chk("irq_idle", irq, 1'b0);
        @(posedge pclk);
        comm_fault <= 1'b1;
        settle();
        @(posedge pclk);
        comm_fault <= 1'b0;
        settle();
        chk("irq_sticky", irq, 1'b1);
        apb(`TSW_OFF_IRQ_STAT, 1'b0, 32'h0);
        chk("irq_stat", rd[5], 1'b1);
        apb(`TSW_OFF_IRQ_STAT, 1'b1, 32'h20);
        settle();
        chk("irq_clear", irq, 1'b0);
        apb(`TSW_OFF_IRQ_MASK, 1'b1, 32'h0);
        comm_fault <= 1'b1;
        settle();
        chk("irq_masked", irq, 1'b0);
        check_all();
        apb(`TSW_OFF_CJ_TEMP, 1'b0, 32'h0);
        chk("cj_read", rd, {16'h0000, cj_temp});
        conclude();
    end
endmodule // tb_integer_mode_fault_status_words

`default_nettype wire
